// file: src/tmr_capture_filter.sv
// Capture pin noise filter and edge detector
`include "tmr_defines.svh"
module tmr_capture_filter
  import tmr_pkg::*;
#(
  parameter int SAMPLES = `TMR_FILTER_SAMPLES
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic capture_pin_in,
  input wire logic capture_noise_filter_in,
  input wire logic capture_edge_select_in,
  input wire logic capture_mode_enable_in,
  output logic capture_event_out
);
  logic [SAMPLES-1:0] sample_reg;
  logic filtered_reg;
  logic filtered_prev_reg;
  logic all_high;
  logic all_low;

  assign all_high = &sample_reg;
  assign all_low = ~|sample_reg;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      sample_reg <= '0;
    end else if (ce_in) begin
      sample_reg <= {sample_reg[SAMPLES-2:0], capture_pin_in};
    end
  end

  // With the filter on, filtered level moves only on a full run of equal samples; with it off it follows each sample
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      filtered_reg <= 1'b0;
    end else if (ce_in) begin
      if (!capture_noise_filter_in) begin
        filtered_reg <= sample_reg[0];
      end else if (all_high) begin
        filtered_reg <= 1'b1;
      end else if (all_low) begin
        filtered_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      filtered_prev_reg <= 1'b0;
      capture_event_out <= 1'b0;
    end else if (ce_in) begin
      filtered_prev_reg <= filtered_reg;
      capture_event_out <= capture_mode_enable_in &&
        (capture_edge_select_in ? (filtered_reg && !filtered_prev_reg)
                                : (!filtered_reg && filtered_prev_reg));
    end
  end

  property p_filter_run;
    @(posedge clk_sys_in) disable iff (rst_in)
    (ce_in && capture_noise_filter_in && !all_high && !all_low)
      |=> $stable(filtered_reg);
  endproperty
  a_filter_run: assert property (p_filter_run) else $error("filter moved without run");

  sequence s_rise_seen;
    ce_in && filtered_reg && !filtered_prev_reg;
  endsequence
  property p_edge_select;
    @(posedge clk_sys_in) disable iff (rst_in)
    s_rise_seen ##0 (capture_mode_enable_in && capture_edge_select_in)
      |=> capture_event_out;
  endproperty
  a_edge_select: assert property (p_edge_select) else $error("rising edge not captured");
endmodule

// file: src/tmr_defines.svh
// Register offsets, control field positions, reset values and timing counts
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH

`define TMR_ADDR_W 6
`define TMR_ADDR_CNT_LO 6'h23
`define TMR_ADDR_CONTROL 6'h24
`define TMR_ADDR_CNT_HI 6'h27

`define TMR_CTL_WIDTH_BIT 7
`define TMR_CTL_CAP_EN_BIT 6
`define TMR_CTL_FILTER_BIT 5
`define TMR_CTL_EDGE_BIT 4
`define TMR_CTL_CTC_BIT 3
`define TMR_CTL_CS_MSB 2
`define TMR_CTL_CS_LSB 0

`define TMR_CONTROL_RESET 8'h00
`define TMR_COUNT_RESET 16'h0000
`define TMR_TEMP_RESET 8'h00

`define TMR_FILTER_SAMPLES 4
`define TMR_MAX8 8'hff
`define TMR_MAX16 16'hffff

`endif

// file: src/tmr_pkg.sv
// Types shared by the timer control and capture logic
package tmr_pkg;
  typedef enum logic [2:0] {
    TMR_CS_STOP = 3'h0,
    TMR_CS_DIV1 = 3'h1,
    TMR_CS_DIV8 = 3'h2,
    TMR_CS_DIV64 = 3'h3,
    TMR_CS_DIV256 = 3'h4,
    TMR_CS_DIV1024 = 3'h5,
    TMR_CS_EXT_FALL = 3'h6,
    TMR_CS_EXT_RISE = 3'h7
  } tmr_clk_sel_e;

  typedef logic [7:0] tmr_byte_t;
endpackage

// file: src/tmr_timer1.sv
// Timer/counter control, clock select, counter and shared temporary byte
// Notes on behaviour
// - Width bit one: 16-bit counter, compare A and B form one 16-bit value.
// - Capture-enable bit 6 set selects input capture mode.
// - Noise filter: filtered input changes after four equal samples.
// - Edge select zero captures falling edge, one captures rising edge.
// - Capture copies counter to capture register and sets capture flag.
// - Bit 3 selects normal counting or clear-on-compare counting, in 8-bit non-capture mode only.
// - Clock select: stop, undivided, /8, /64, /256, /1024, pin fall, pin rise.
// - External pin edges count even when the pin is driven as output.
// - Writing counter low byte blocks compare match on next timer tick.
// - Low byte reads and writes counter bits 7 to 0 directly.
// - 16-bit mode reaches high byte through one shared temporary byte.
// - Temporary byte keeps its value between accesses.
// - Low write loads temp and data together; low read copies high to temp.
// - Clear-on-compare mode clears counter on match with compare A.
// - Overflow flag sets in the tick where counter wraps from max to zero.
`include "tmr_defines.svh"
module tmr_timer1
  import tmr_pkg::*;
#(
  parameter int ADDR_W = `TMR_ADDR_W
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] wdata_in,
  input wire logic [3:0] prescale_tick_in,
  input wire logic external_count_pin_in,
  input wire logic capture_pin_in,
  input wire logic [7:0] compare_register_a_in,
  input wire logic [7:0] compare_register_b_in,
  output logic [7:0] rdata_out,
  output logic [7:0] timer_control_out,
  output logic [15:0] count_out,
  output logic [7:0] temp_out,
  output logic [15:0] capture_value_out,
  output logic capture_flag_set_out,
  output logic overflow_flag_set_out,
  output logic compare_match_a_out,
  output logic compare_match_b_out
);
  logic [7:0] control_reg;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [7:0] temp_reg;
  logic ext_prev_reg;
  logic block_reg;
  logic tick;
  logic wide;
  logic cap_mode;
  logic ctc;
  logic wr_lo;
  logic wr_hi;
  logic wr_ctl;
  logic rd_lo;
  logic at_max;
  logic match_a;
  logic match_b;
  logic match_ok;
  logic capture_event;
  tmr_clk_sel_e clk_sel;

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
    return a == b;
  endfunction

  assign wide = control_reg[`TMR_CTL_WIDTH_BIT];
  assign cap_mode = control_reg[`TMR_CTL_CAP_EN_BIT];
  assign ctc = control_reg[`TMR_CTL_CTC_BIT] && !wide && !cap_mode;
  assign clk_sel = tmr_clk_sel_e'(control_reg[`TMR_CTL_CS_MSB:`TMR_CTL_CS_LSB]);
  assign wr_lo = wr_en_in && addr_hit(addr_in, ADDR_W'(`TMR_ADDR_CNT_LO));
  assign wr_hi = wr_en_in && addr_hit(addr_in, ADDR_W'(`TMR_ADDR_CNT_HI));
  assign wr_ctl = wr_en_in && addr_hit(addr_in, ADDR_W'(`TMR_ADDR_CONTROL));
  assign rd_lo = rd_en_in && addr_hit(addr_in, ADDR_W'(`TMR_ADDR_CNT_LO));

  // Timer tick from the selected source
  always_comb begin
    unique case (clk_sel)
      TMR_CS_STOP: tick = 1'b0;
      TMR_CS_DIV1: tick = 1'b1;
      TMR_CS_DIV8: tick = prescale_tick_in[0];
      TMR_CS_DIV64: tick = prescale_tick_in[1];
      TMR_CS_DIV256: tick = prescale_tick_in[2];
      TMR_CS_DIV1024: tick = prescale_tick_in[3];
      TMR_CS_EXT_FALL: tick = ext_prev_reg && !external_count_pin_in;
      TMR_CS_EXT_RISE: tick = !ext_prev_reg && external_count_pin_in;
    endcase
  end

  // Pin level is sampled regardless of its port direction
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ext_prev_reg <= 1'b0;
    end else if (ce_in) begin
      ext_prev_reg <= external_count_pin_in;
    end
  end

  assign at_max = wide ? (count_reg == `TMR_MAX16) : (count_reg[7:0] == `TMR_MAX8);
  assign match_a = wide ? (count_reg == {compare_register_b_in, compare_register_a_in})
                        : (count_reg[7:0] == compare_register_a_in);
  assign match_b = !wide && (count_reg[7:0] == compare_register_b_in);
  assign match_ok = tick && !block_reg && !cap_mode;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      control_reg <= `TMR_CONTROL_RESET;
    end else if (ce_in && wr_ctl) begin
      control_reg <= wdata_in;
    end
  end

  // Compare block from a low-byte write until the next tick has passed
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      block_reg <= 1'b0;
    end else if (ce_in) begin
      if (wr_lo) begin
        block_reg <= 1'b1;
      end else if (tick) begin
        block_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    count_next = count_reg;
    if (tick) begin
      if (ctc && match_a && !block_reg) begin
        count_next[7:0] = 8'h00;
      end else if (wide) begin
        count_next = count_reg + 16'h0001;
      end else begin
        count_next[7:0] = count_reg[7:0] + 8'h01;
      end
    end
    if (wr_hi && !wide) begin
      count_next[15:8] = wdata_in;
    end
    if (wr_lo) begin
      count_next = wide ? {temp_reg, wdata_in} : {count_reg[15:8], wdata_in};
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      count_reg <= `TMR_COUNT_RESET;
    end else if (ce_in) begin
      count_reg <= count_next;
    end
  end

  // Shared temporary byte; holds between accesses
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      temp_reg <= `TMR_TEMP_RESET;
    end else if (ce_in && wide) begin
      if (wr_hi) begin
        temp_reg <= wdata_in;
      end else if (rd_lo) begin
        temp_reg <= count_reg[15:8];
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else if (ce_in && rd_en_in) begin
      if (addr_hit(addr_in, ADDR_W'(`TMR_ADDR_CNT_LO))) begin
        rdata_out <= count_reg[7:0];
      end else if (addr_hit(addr_in, ADDR_W'(`TMR_ADDR_CNT_HI))) begin
        rdata_out <= wide ? temp_reg : count_reg[15:8];
      end else if (addr_hit(addr_in, ADDR_W'(`TMR_ADDR_CONTROL))) begin
        rdata_out <= control_reg;
      end else begin
        rdata_out <= 8'h00;
      end
    end
  end

  tmr_capture_filter u_capture_filter (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .capture_pin_in(capture_pin_in),
    .capture_noise_filter_in(control_reg[`TMR_CTL_FILTER_BIT]),
    .capture_edge_select_in(control_reg[`TMR_CTL_EDGE_BIT]),
    .capture_mode_enable_in(cap_mode),
    .capture_event_out(capture_event)
  );

  // Event pulses and capture value
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      capture_value_out <= 16'h0000;
      capture_flag_set_out <= 1'b0;
      overflow_flag_set_out <= 1'b0;
      compare_match_a_out <= 1'b0;
      compare_match_b_out <= 1'b0;
    end else if (ce_in) begin
      if (capture_event) begin
        capture_value_out <= wide ? count_reg : {8'h00, count_reg[7:0]};
      end
      capture_flag_set_out <= capture_event;
      // A clear-on-compare at max is also a wrap to zero
      overflow_flag_set_out <= tick && !wr_lo && at_max;
      compare_match_a_out <= match_ok && match_a;
      compare_match_b_out <= match_ok && match_b;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      timer_control_out <= `TMR_CONTROL_RESET;
      count_out <= `TMR_COUNT_RESET;
      temp_out <= `TMR_TEMP_RESET;
    end else begin
      timer_control_out <= control_reg;
      count_out <= count_reg;
      temp_out <= temp_reg;
    end
  end

  sequence s_hi_then_lo;
    ce_in && wide && wr_lo;
  endsequence
  property p_lo_write16;
    @(posedge clk_sys_in) disable iff (rst_in)
    s_hi_then_lo |=> count_reg == {$past(temp_reg), $past(wdata_in)};
  endproperty
  a_lo_write16: assert property (p_lo_write16) else $error("16-bit write not joined");

  property p_lo_read_temp;
    @(posedge clk_sys_in) disable iff (rst_in)
    (ce_in && wide && rd_lo && !wr_hi) |=> temp_reg == $past(count_reg[15:8]);
  endproperty
  a_lo_read_temp: assert property (p_lo_read_temp) else $error("high byte not latched");

  property p_temp_hold;
    @(posedge clk_sys_in) disable iff (rst_in)
    (!rd_en_in && !wr_en_in) |=> $stable(temp_reg);
  endproperty
  a_temp_hold: assert property (p_temp_hold) else $error("temporary byte changed");

  property p_stopped;
    @(posedge clk_sys_in) disable iff (rst_in)
    (clk_sel == TMR_CS_STOP && !wr_en_in) |=> $stable(count_reg);
  endproperty
  a_stopped: assert property (p_stopped) else $error("stopped counter moved");

  property p_block;
    @(posedge clk_sys_in) disable iff (rst_in)
    (ce_in && wr_lo) ##1 (ce_in && tick) |=> !compare_match_a_out && !compare_match_b_out;
  endproperty
  a_block: assert property (p_block) else $error("match after low write");

  property p_ctc_clear;
    @(posedge clk_sys_in) disable iff (rst_in)
    (ce_in && tick && ctc && match_a && !block_reg && !wr_en_in) |=> count_reg[7:0] == 8'h00;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("no clear on compare");

  property p_overflow16;
    @(posedge clk_sys_in) disable iff (rst_in)
    (ce_in && tick && wide && count_reg == 16'hffff && !wr_en_in)
      |=> overflow_flag_set_out && count_reg == 16'h0000;
  endproperty
  a_overflow16: assert property (p_overflow16) else $error("16-bit wrap missed");

  property p_capture;
    @(posedge clk_sys_in) disable iff (rst_in)
    (ce_in && capture_event && wide)
      |=> capture_flag_set_out && capture_value_out == $past(count_reg);
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong");

  property p_div1_count;
    @(posedge clk_sys_in) disable iff (rst_in)
    (ce_in && clk_sel == TMR_CS_DIV1 && wide && !wr_en_in)
      |=> count_reg == $past(count_reg) + 16'h0001;
  endproperty
  a_div1_count: assert property (p_div1_count) else $error("undivided count wrong");
endmodule

// file: test/tmr_cpu_model.sv
// Processor core model driving the timer register bus
`include "tmr_defines.svh"
module tmr_cpu_model (
  input wire logic clk_sys_in,
  input wire logic [7:0] rdata_in,
  output logic [`TMR_ADDR_W-1:0] addr_out,
  output logic wr_en_out,
  output logic rd_en_out,
  output logic [7:0] wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr_out = 6'h00;
    wr_en_out = 1'h0;
    rd_en_out = 1'h0;
    wdata_out = 8'h00;
  end

  // No interrupt source here, so two-byte accesses never interleave
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge clk_sys_in);
    addr_out <= a;
    wdata_out <= v;
    wr_en_out <= 1'h1;
    @(posedge clk_sys_in);
    wr_en_out <= 1'h0;
    wdata_out <= ~v;
  endtask

  // Read data holds until next read, so sample late
  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    @(posedge clk_sys_in);
    addr_out <= a;
    rd_en_out <= 1'h1;
    @(posedge clk_sys_in);
    rd_en_out <= 1'h0;
    repeat (2) @(posedge clk_sys_in);
    v = rdata_in;
  endtask
endmodule

// file: test/tmr_timer1_tb.sv
// Self-checking bench for the timer control and counter block
`include "tmr_defines.svh"
module tmr_timer1_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] LO = `TMR_ADDR_CNT_LO;
  localparam logic [5:0] CT = `TMR_ADDR_CONTROL;
  localparam logic [5:0] HI = `TMR_ADDR_CNT_HI;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic ext = 1'h0;
  logic cap = 1'h0;
  logic ce = 1'h1;
  logic [3:0] tick = 4'h0;
  logic [7:0] cmp_a = 8'h00;
  logic [7:0] cmp_b = 8'h00;
  logic [5:0] addr;
  logic wr_en;
  logic rd_en;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] ctl;
  logic [15:0] cnt;
  logic [7:0] tmp;
  logic [15:0] capv;
  wire [3:0] pv;
  logic [7:0] d;
  logic [7:0] mx;
  int err_count = 0;
  int checked = 0;
  // Address, write data, expected read back
  logic [21:0] rows [7] = '{{CT, 8'h80, 8'h80}, {CT, 8'h40, 8'h40}, {CT, 8'h20, 8'h20},
    {CT, 8'h10, 8'h10}, {CT, 8'h08, 8'h08}, {CT, 8'h07, 8'h07}, {6'h25, 8'haa, 8'h00}};

  always #10 clk = ~clk;

  tmr_cpu_model tmr_cpu_model_inst (.clk_sys_in(clk), .rdata_in(rdata), .addr_out(addr),
    .wr_en_out(wr_en), .rd_en_out(rd_en), .wdata_out(wdata));

  tmr_timer1 tmr_timer1_inst (.clk_sys_in(clk), .rst_in(rst), .ce_in(ce), .addr_in(addr),
    .wr_en_in(wr_en), .rd_en_in(rd_en), .wdata_in(wdata), .prescale_tick_in(tick),
    .external_count_pin_in(ext), .capture_pin_in(cap), .compare_register_a_in(cmp_a),
    .compare_register_b_in(cmp_b), .rdata_out(rdata), .timer_control_out(ctl),
    .count_out(cnt), .temp_out(tmp), .capture_value_out(capv),
    .capture_flag_set_out(pv[0]), .overflow_flag_set_out(pv[2]),
    .compare_match_a_out(pv[1]), .compare_match_b_out(pv[3]));

  task automatic print_verdict();
    if (err_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Pulse seen within lim cycles or not
  task automatic wait_ev(input int s, input int lim, input logic e);
    logic hit;
    hit = 1'h0;
    for (int i = 0; i < lim && !hit; i++) begin
      @(posedge clk);
      hit = (pv[s] === 1'h1);
    end
    chk({15'h0000, hit}, {15'h0000, e});
    if (e && !hit) print_verdict();
  endtask

  task automatic w(input logic [5:0] a, input logic [7:0] v);
    tmr_cpu_model_inst.wr(a, v);
  endtask

  task automatic r(input logic [5:0] a, output logic [7:0] v);
    tmr_cpu_model_inst.rd(a, v);
  endtask

  task automatic tk(input logic [3:0] v);
    @(posedge clk);
    tick <= v;
    @(posedge clk);
    tick <= 4'h0;
  endtask

  task automatic cp(input logic l, input logic e);
    @(posedge clk);
    cap <= l;
    wait_ev(0, 12, e);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    repeat (2) @(posedge clk);
    chk(cnt, 16'h0000);
    chk({8'h00, ctl}, 16'h0000);
    foreach (rows[i]) begin
      w(rows[i][21:16], rows[i][15:8]);
      r(rows[i][21:16], d);
      chk({8'h00, d}, {8'h00, rows[i][7:0]});
    end
    w(CT, 8'h80);
    w(HI, 8'h01);
    w(LO, 8'hff);
    repeat (2) @(posedge clk);
    chk(cnt, 16'h01ff);
    r(LO, d);
    chk({8'h00, d}, 16'h00ff);
    chk({8'h00, tmp}, 16'h0001);
    r(HI, d);
    chk({8'h00, d}, 16'h0001);
    w(LO, 8'h34);
    repeat (2) @(posedge clk);
    chk(cnt, 16'h0134);
    w(CT, 8'h00);
    w(HI, 8'h00);
    w(LO, 8'hfd);
    w(CT, 8'h01);
    wait_ev(2, 10, 1'h1);
    // Clock enable low freezes a running count
    ce <= 1'h0;
    repeat (2) @(posedge clk);
    mx = cnt[7:0];
    repeat (5) @(posedge clk);
    chk({8'h00, cnt[7:0]}, {8'h00, mx});
    ce <= 1'h1;
    w(CT, 8'h00);
    repeat (2) @(posedge clk);
    mx = cnt[7:0];
    repeat (5) @(posedge clk);
    chk({8'h00, cnt[7:0]}, {8'h00, mx});
    // Each prescaler tap alone advances the count
    for (int k = 0; k < 4; k++) begin
      w(LO, 8'h00);
      w(CT, 8'h02 + 8'(k));
      repeat (2) @(posedge clk);
      tk(4'h1 << k);
      tk(4'h1 << k);
      tk(~(4'h1 << k));
      repeat (3) @(posedge clk);
      chk({8'h00, cnt[7:0]}, 16'h0002);
      w(CT, 8'h00);
    end
    // Three rising and two falling pin edges
    for (int c = 6; c < 8; c++) begin
      @(posedge clk);
      ext <= 1'h0;
      w(LO, 8'h00);
      w(CT, 8'(c));
      repeat (2) @(posedge clk);
      repeat (5) begin
        @(posedge clk);
        ext <= ~ext;
        @(posedge clk);
      end
      repeat (3) @(posedge clk);
      chk({8'h00, cnt[7:0]}, (c == 7) ? 16'h0003 : 16'h0002);
      w(CT, 8'h00);
    end
    w(LO, 8'h5a);
    w(CT, 8'h50);
    cp(1'h1, 1'h1);
    chk(capv, 16'h005a);
    cp(1'h0, 1'h0);
    w(CT, 8'h40);
    cp(1'h1, 1'h0);
    cp(1'h0, 1'h1);
    w(CT, 8'h70);
    @(posedge clk);
    cap <= 1'h1;
    repeat (3) @(posedge clk);
    cap <= 1'h0;
    wait_ev(0, 12, 1'h0);
    cp(1'h1, 1'h1);
    w(CT, 8'hc0);
    w(HI, 8'h12);
    w(LO, 8'h34);
    cp(1'h0, 1'h1);
    chk(capv, 16'h1234);
    w(CT, 8'h00);
    w(LO, 8'h00);
    cmp_a <= 8'h05;
    w(CT, 8'h09);
    mx = 8'h00;
    repeat (30) begin
      @(posedge clk);
      if (cnt[7:0] > mx) mx = cnt[7:0];
    end
    chk({8'h00, mx}, 16'h0005);
    wait_ev(1, 10, 1'h1);
    w(CT, 8'h00);
    w(LO, 8'h10);
    w(CT, 8'h01);
    w(LO, 8'h05);
    wait_ev(1, 6, 1'h0);
    w(LO, 8'h04);
    wait_ev(1, 6, 1'h1);
    cmp_b <= 8'h0c;
    wait_ev(3, 12, 1'h1);
    w(CT, 8'h80);
    w(HI, 8'hff);
    w(LO, 8'hfd);
    w(CT, 8'h81);
    wait_ev(2, 10, 1'h1);
    w(CT, 8'h00);
    cmp_a <= 8'h00;
    cmp_b <= 8'h03;
    w(HI, 8'h01);
    w(LO, 8'hfc);
    w(CT, 8'h81);
    wait_ev(3, 12, 1'h0);
    wait_ev(1, 12, 1'h0);
    wait_ev(1, 300, 1'h1);
    print_verdict();
  end
endmodule
